// ---- rtl/mrg_defs.svh ----
// Offsets, field positions, reset values and sequencer counts of the reset generator.
`ifndef MRG_DEFS_SVH
`define MRG_DEFS_SVH
`define MRG_OFS_SYSCTL 12'h000
`define MRG_OFS_WDTCTL 12'h004
`define MRG_OFS_STATUS 12'h008
`define MRG_BIT_HFEN 7
`define MRG_BIT_LFEN 6
`define MRG_BIT_CLKSEL 5
`define MRG_BIT_TRAPRST 1
`define MRG_BIT_TRAPRAM 0
`define MRG_BIT_PINLVL 8
`define MRG_BIT_INRST 9
`define MRG_RST_SYSCTL 3'h4
`define MRG_RST_WDTCTL 2'h2
`define MRG_VECTOR 16'hFFFE
`define MRG_CLK_PER_FC 1
`define MRG_DRIVE_FC 24
`define MRG_HOLD_FC 8
`define MRG_RELEASE_FC 16
`define MRG_EXT_MIN_FC 12
`define MRG_DRIVE_CYC (`MRG_DRIVE_FC * `MRG_CLK_PER_FC)
`define MRG_HOLD_CYC (`MRG_HOLD_FC * `MRG_CLK_PER_FC)
`define MRG_RELEASE_CYC (`MRG_RELEASE_FC * `MRG_CLK_PER_FC)
`endif

// ---- rtl/mrg_pkg.sv ----
// Types shared by the reset generator: sequencer states and register layouts.
package mrg_pkg;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b0_0001,
      ST_DRIVE = 5'b0_0010,
      ST_HOLD = 5'b0_0100,
      ST_EXT = 5'b0_1000,
      ST_RELEASE = 5'b1_0000
   } mrg_state_t;
   typedef struct packed {
      logic hfOscEn;
      logic lfOscEn;
      logic mainClkSel;
   } mrg_sysctl_t;
   typedef struct packed {
      logic trapToReset;
      logic trapRamSel;
   } mrg_wdtctl_t;
   typedef struct packed {
      logic clockCheck;
      logic watchdog;
      logic addressTrap;
      logic externalPin;
   } mrg_cause_t;
   typedef struct packed {
      logic clearIntState;
      logic clearTimingGen;
      logic forceWatchdogOn;
   } mrg_init_t;
endpackage : mrg_pkg

// ---- rtl/mrg_top.sv ----
`timescale 1ns/10ps
// Reset generator: merges pin, address trap, watchdog and clock-check resets and sequences release.
`include "mrg_defs.svh"
// Behaviour
// [RULE_01] Four reset sources; trap, watchdog and clock check are malfunction resets.
// [RULE_02] A malfunction reset drives the pin low for at most 24 clocks.
// [RULE_03] Malfunction logic may give a 24-clock pin-low pulse at power-up.
// [RULE_04] The outside holds the pin low at least twelve clocks to reset.
// [RULE_05] Pin going high releases reset; execution starts from the vector at top two bytes.
// [RULE_06] Reset clears interrupt enables and latches and loads the reset vector.
// [RULE_07] Reset clears timing generator, enables watchdog, leaves CPU state and RAM alone.
// [RULE_08] Fetches from special function, data buffer or selected RAM regions raise a trap.
// [RULE_09] Software picks trap reset versus interrupt and whether RAM is covered.
// [RULE_10] Internal reset outlasts the pin pulse 4 to 12 clocks, then 16-clock release.
// [RULE_11] Clock reset when one write clears both oscillator enables.
// [RULE_12] Clock reset when high-frequency enable is cleared while it clocks the core.
// [RULE_13] Clock reset when low-frequency enable is cleared while it clocks the core.
// [RULE_14] A clock reset keeps both oscillators running.
// [RULE_15] All requests merge into one reset; the pin is only ever pulled low.
module mrg_top #(
   parameter logic [15:0] SFR_FIRST = 16'h0000,
   parameter logic [15:0] SFR_LAST = 16'h003F,
   parameter logic [15:0] RAM_FIRST = 16'h0040,
   parameter logic [15:0] RAM_LAST = 16'h023F,
   parameter logic [15:0] DBR_FIRST = 16'h0F80,
   parameter logic [15:0] DBR_LAST = 16'h0FFF
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic resetNIn,
   output logic resetNOut,
   output logic resetNOe,
   input wire logic fetchValid,
   input wire logic [15:0] fetchAddr,
   input wire logic watchdogReq,
   output logic cpuReset,
   output logic vectorLoad,
   output logic [15:0] vectorAddr,
   output mrg_pkg::mrg_init_t initCtl,
   output mrg_pkg::mrg_sysctl_t sysCtl,
   output logic trapIrq
);

   // Inclusive address window test, shared by all trap regions.
   function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      inRange = (a >= lo) && (a <= hi);
   endfunction : inRange

   // Register select: 0 none, 1 clock control, 2 trap control, 3 status.
   function automatic logic [1:0] regSel(input logic [11:0] a);
      unique case (a)
         `MRG_OFS_SYSCTL: regSel = 2'h1;
         `MRG_OFS_WDTCTL: regSel = 2'h2;
         `MRG_OFS_STATUS: regSel = 2'h3;
         default: regSel = 2'h0;
      endcase
   endfunction : regSel

   mrg_pkg::mrg_state_t state_q, state_d;
   logic [4:0] cnt_q, cnt_d;
   logic pinMeta_q, pinSync_q;
   logic cpuReset_q, resetNOe_q, resetNOut_q, vectorLoad_q, trapIrq_q, trapIrq_d;
   logic [15:0] vectorAddr_q;
   mrg_pkg::mrg_init_t initCtl_q;
   mrg_pkg::mrg_sysctl_t sysCtl_q, sysCtl_d, sysWr;
   mrg_pkg::mrg_wdtctl_t wdtCtl_q, wdtCtl_d;
   mrg_pkg::mrg_cause_t cause_q, cause_d, causeSet, causeClr;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pslverr_q;
   logic wrEn, trapHit, trapReset, clkFault, malfReq, inReset_d;

   // Two-stage synchroniser for the reset pin; only the second stage is read.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinMeta_q <= 1'b1;
         pinSync_q <= 1'b1;
      end else begin
         pinMeta_q <= resetNIn;
         pinSync_q <= pinMeta_q;
      end
   end

   // Request decoding: a write takes effect in the access cycle only.
   always_comb begin
      wrEn = psel && penable && pready_q && pwrite && (regSel(paddr) == 2'h1 || regSel(paddr) == 2'h2);
      sysWr = mrg_pkg::mrg_sysctl_t'({pwdata[`MRG_BIT_HFEN], pwdata[`MRG_BIT_LFEN], pwdata[`MRG_BIT_CLKSEL]});
      // Fetches during reset are meaningless, so they cannot trap.
      trapHit = fetchValid && !cpuReset_q &&
         (inRange(fetchAddr, SFR_FIRST, SFR_LAST) || inRange(fetchAddr, DBR_FIRST, DBR_LAST) || // RULE_08
          (wdtCtl_q.trapRamSel && inRange(fetchAddr, RAM_FIRST, RAM_LAST)));
      trapReset = trapHit && wdtCtl_q.trapToReset; // RULE_09
      clkFault = wrEn && regSel(paddr) == 2'h1 &&
         ((!sysWr.hfOscEn && !sysWr.lfOscEn) || // RULE_11
          (!sysWr.hfOscEn && !sysCtl_q.mainClkSel) || // RULE_12
          (!sysWr.lfOscEn && sysCtl_q.mainClkSel)); // RULE_13
      malfReq = trapReset || watchdogReq || clkFault; // RULE_01
   end

   // Sequencer: drive the pin, hold the core, then release through the vector fetch.
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      unique case (state_q)
         mrg_pkg::ST_IDLE: begin
            if (malfReq) begin
               state_d = mrg_pkg::ST_DRIVE; // RULE_02
               cnt_d = 5'h00;
            end else if (!pinSync_q) begin
               state_d = mrg_pkg::ST_EXT; // RULE_04
            end
         end
         mrg_pkg::ST_DRIVE: begin
            if (cnt_q == 5'(`MRG_DRIVE_CYC - 1)) begin
               state_d = mrg_pkg::ST_HOLD;
               cnt_d = 5'h00;
            end else begin
               cnt_d = cnt_q + 5'h01;
            end
         end
         mrg_pkg::ST_HOLD: begin
            // The hold also covers the pin's rise time and synchroniser delay.
            if (cnt_q == 5'(`MRG_HOLD_CYC - 1)) begin
               state_d = pinSync_q ? mrg_pkg::ST_RELEASE : mrg_pkg::ST_EXT; // RULE_10
               cnt_d = 5'h00;
            end else begin
               cnt_d = cnt_q + 5'h01;
            end
         end
         mrg_pkg::ST_EXT: begin
            if (pinSync_q) begin
               state_d = mrg_pkg::ST_RELEASE; // RULE_05
               cnt_d = 5'h00;
            end
         end
         mrg_pkg::ST_RELEASE: begin
            if (malfReq) begin
               state_d = mrg_pkg::ST_DRIVE;
               cnt_d = 5'h00;
            end else if (!pinSync_q) begin
               state_d = mrg_pkg::ST_EXT;
            end else if (cnt_q == 5'(`MRG_RELEASE_CYC - 1)) begin
               state_d = mrg_pkg::ST_IDLE; // RULE_10
               cnt_d = 5'h00;
            end else begin
               cnt_d = cnt_q + 5'h01;
            end
         end
      endcase
      inReset_d = state_d inside {mrg_pkg::ST_DRIVE, mrg_pkg::ST_HOLD, mrg_pkg::ST_EXT}; // RULE_15
   end

   // Sequencer registers. Reset lands in the drive state, so power-up gives one full pin pulse.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= mrg_pkg::ST_DRIVE; // RULE_03
         cnt_q <= 5'h00;
         cpuReset_q <= 1'b1;
         resetNOe_q <= 1'b1;
         resetNOut_q <= 1'b0;
         vectorLoad_q <= 1'b0;
         vectorAddr_q <= `MRG_VECTOR;
         initCtl_q <= 3'h7;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cpuReset_q <= inReset_d;
         resetNOe_q <= (state_d == mrg_pkg::ST_DRIVE); // RULE_02
         resetNOut_q <= 1'b0; // RULE_15
         vectorLoad_q <= (state_d == mrg_pkg::ST_RELEASE) && (state_q != mrg_pkg::ST_RELEASE); // RULE_05
         vectorAddr_q <= `MRG_VECTOR; // RULE_06
         // Only these blocks are cleared; stack, registers, flags and RAM keep their contents.
         initCtl_q <= {3{inReset_d}}; // RULE_06 RULE_07
      end
   end

   // Register next values: writes, hardware reinitialisation and sticky causes.
   always_comb begin
      sysCtl_d = sysCtl_q;
      wdtCtl_d = wdtCtl_q;
      // A faulting write is dropped whole, so the oscillators keep running.
      if (wrEn && regSel(paddr) == 2'h1 && !clkFault) begin
         sysCtl_d = sysWr; // RULE_14
      end
      if (wrEn && regSel(paddr) == 2'h2) begin
         wdtCtl_d = mrg_pkg::mrg_wdtctl_t'({pwdata[`MRG_BIT_TRAPRST], pwdata[`MRG_BIT_TRAPRAM]});
      end
      // Internal reset returns to the fast clock and trap-to-reset.
      if (cpuReset_q) begin
         sysCtl_d.hfOscEn = 1'b1;
         sysCtl_d.mainClkSel = 1'b0;
         wdtCtl_d = `MRG_RST_WDTCTL;
      end
      causeSet = mrg_pkg::mrg_cause_t'({clkFault, watchdogReq, trapReset, state_q == mrg_pkg::ST_IDLE && !pinSync_q});
      causeClr = 4'h0;
      if (psel && penable && pready_q && pwrite && regSel(paddr) == 2'h3) begin
         causeClr = pwdata[3:0];
      end
      // Set wins over a clear in the same cycle.
      cause_d = (cause_q & ~causeClr) | causeSet;
      trapIrq_d = trapHit && !wdtCtl_q.trapToReset; // RULE_09
      unique case (regSel(paddr))
         2'h1: prdata_d = {24'h00_0000, sysCtl_q, 5'h00};
         2'h2: prdata_d = {30'h0000_0000, wdtCtl_q};
         2'h3: prdata_d = {22'h00_0000, cpuReset_q, pinSync_q, 4'h0, cause_q};
         default: prdata_d = 32'h0000_0000;
      endcase
   end

   // Bus slave registers: read data and ready are set up in the setup cycle, one wait-free access.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sysCtl_q <= `MRG_RST_SYSCTL;
         wdtCtl_q <= `MRG_RST_WDTCTL;
         cause_q <= 4'h0;
         trapIrq_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         sysCtl_q <= sysCtl_d;
         wdtCtl_q <= wdtCtl_d;
         cause_q <= cause_d;
         trapIrq_q <= trapIrq_d;
         prdata_q <= (psel && !penable && !pwrite) ? prdata_d : 32'h0000_0000;
         pready_q <= psel && !penable;
         pslverr_q <= psel && !penable && regSel(paddr) == 2'h0;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign resetNOut = resetNOut_q;
   assign resetNOe = resetNOe_q;
   assign cpuReset = cpuReset_q;
   assign vectorLoad = vectorLoad_q;
   assign vectorAddr = vectorAddr_q;
   assign initCtl = initCtl_q;
   assign sysCtl = sysCtl_q;
   assign trapIrq = trapIrq_q;

   // Helper: length of the current pin-drive run.
   // It does not saturate; a run past 63 cycles would wrap, but chk_drive_bound fires long before.
   logic [5:0] oeRun_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         oeRun_q <= 6'h00;
      end else begin
         oeRun_q <= resetNOe_q ? 6'(oeRun_q + 6'h01) : 6'h00;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_drive_length: assert property ($fell(resetNOe) |-> oeRun_q == 6'd24) // RULE_02
      else $error("Pin drive pulse not 24 cycles.");
   chk_drive_bound: assert property (oeRun_q <= 6'd24) // RULE_03
      else $error("Pin drive pulse too long.");
   chk_hold_after: assert property ($fell(resetNOe) |-> cpuReset [*8]) // RULE_10
      else $error("Internal reset ended too soon after the pin pulse.");
   chk_vector_load: assert property ($fell(cpuReset) |-> vectorLoad && vectorAddr == 16'hFFFE) // RULE_05
      else $error("Reset release without vector load.");
   chk_pin_pull_low: assert property (!resetNOut && (!resetNOe || cpuReset)) // RULE_15
      else $error("Pin driven high or driven outside reset.");
   chk_clock_fault: assert property (clkFault && state_q == mrg_pkg::ST_IDLE |=> resetNOe && cpuReset) // RULE_11
      else $error("Clock fault did not start a reset.");
   chk_osc_kept: assert property (clkFault && !cpuReset |=> $stable(sysCtl)) // RULE_14
      else $error("Oscillator enables changed on a faulting write.");
   chk_trap_reset: assert property (trapReset && state_q == mrg_pkg::ST_IDLE |=> resetNOe) // RULE_08
      else $error("Address trap did not reset.");
   chk_trap_irq: assert property (trapHit && !wdtCtl_q.trapToReset && !malfReq |=> trapIrq && !resetNOe) // RULE_09
      else $error("Address trap interrupt missing.");
   chk_ext_reset: assert property (!pinSync_q && state_q == mrg_pkg::ST_IDLE && !malfReq |=> cpuReset) // RULE_04
      else $error("Pin low did not reset.");
   chk_init_clear: assert property (cpuReset |-> initCtl == 3'h7) // RULE_06
      else $error("Init controls not asserted in reset.");
   chk_release_len: assert property (vectorLoad ##1 (pinSync_q && !malfReq) [*8] |-> !cpuReset) // RULE_10
      else $error("Release phase cut short.");

   cov_trap_reset: cover property (trapReset && state_q == mrg_pkg::ST_IDLE ##1 resetNOe);
   cov_clock_fault: cover property (clkFault ##1 resetNOe);
   cov_ext_release: cover property (state_q == mrg_pkg::ST_EXT ##[1:50] vectorLoad);

   // Reinitialisation ends with the reset: the init controls drop in the same cycle as the core reset.
   chk_init_release: assert property ($fell(cpuReset) |-> initCtl == 3'h0) // RULE_07
      else $error("Init controls still asserted after reset release.");
   // While reset is held the core must come back on the fast oscillator, whatever software wrote.
   chk_fast_clock_reinit: assert property (cpuReset |=> sysCtl.hfOscEn && !sysCtl.mainClkSel) // RULE_14
      else $error("Fast oscillator not restored during reset.");

   // Watchdog resets and interrupt-mode traps complete the list of main scenarios.
   cov_watchdog_reset: cover property (watchdogReq && state_q == mrg_pkg::ST_IDLE ##1 resetNOe);
   cov_trap_irq: cover property (trapHit && !wdtCtl_q.trapToReset ##1 trapIrq);

endmodule : mrg_top

// ---- test/mrg_pin_model.sv ----
// Board-side model of the reset line: a supervisor that pulls low on command, plus the pull-up.
`timescale 1ns/10ps
module mrg_pin_model (
   input wire logic clk,
   input wire logic resetNOut,
   input wire logic resetNOe,
   input wire logic holdReq,
   output logic resetNIn
);
   logic extLow;
   // The supervisor changes its pull just after an edge, like any board driver would.
   always_ff @(posedge clk) begin
      extLow <= holdReq;
   end
   // Wired-AND of both pulls; nobody driving leaves the line on its pull-up, never the last value.
   assign resetNIn = ((resetNOe && !resetNOut) || extLow) ? 1'b0 : 1'b1;
endmodule : mrg_pin_model

// ---- test/tb.sv ----
// Self-checking bench for the reset generator: power-up, traps, watchdog, clock faults, pin reset.
`timescale 1ns/10ps
`include "mrg_defs.svh"
module tb;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, fetchValid, watchdogReq, holdReq;
   logic resetNIn, resetNOut, resetNOe, cpuReset, vectorLoad, trapIrq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdData;
   logic [15:0] fetchAddr, vectorAddr;
   mrg_pkg::mrg_init_t initCtl;
   mrg_pkg::mrg_sysctl_t sysCtl;
   int nFail = 0;
   int cmpCount = 0;
   mrg_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .resetNIn(resetNIn),
      .resetNOut(resetNOut), .resetNOe(resetNOe), .fetchValid(fetchValid), .fetchAddr(fetchAddr),
      .watchdogReq(watchdogReq), .cpuReset(cpuReset), .vectorLoad(vectorLoad), .vectorAddr(vectorAddr),
      .initCtl(initCtl), .sysCtl(sysCtl), .trapIrq(trapIrq));
   mrg_pin_model pin (.clk(clk), .resetNOut(resetNOut), .resetNOe(resetNOe), .holdReq(holdReq),
      .resetNIn(resetNIn));
   // Bench clock at 20 MHz.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Single comparison point; case inequality so an unknown never passes.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         nFail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finalReport();
      $display("Comparisons %0d mismatches %0d", cmpCount, nFail);
      if (nFail == 0 && cmpCount > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finalReport
   // One APB transfer; the request stands until pready is seen at a rising edge.
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data, input logic expErr);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge clk);
      penable <= 1'b1;
      // No wait-state count is assumed; the hang guard ends a transfer that never completes.
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdData = prdata;
      check("pslverr", 32'(pslverr), 32'(expErr));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Instruction fetch of one cycle; the trap interrupt, if any, shows in the next cycle.
   task automatic fetch(input logic [15:0] addr, input logic expIrq);
      @(posedge clk);
      fetchValid <= 1'b1;
      fetchAddr <= addr;
      @(posedge clk);
      fetchValid <= 1'b0;
      @(negedge clk);
      check("trapIrq", 32'(trapIrq), 32'(expIrq));
   endtask : fetch
   // Follow one reset from a falling clock edge: measure pin pull and core hold, then the vector load.
   task automatic runSeq(input logic exact, output int m);
      int n, oe;
      n = 0;
      m = 0;
      oe = 0;
      while (cpuReset !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      while (cpuReset === 1'b1 && m < 400) begin
         oe += (resetNOe === 1'b1);
         if (resetNOe === 1'b1) check("resetNOut", 32'(resetNOut), 0);
         check("initCtl", 32'(initCtl), 32'h0000_0007);
         m++;
         @(negedge clk);
      end
      check("pinPulseMax", 32'(oe <= 24), 1);
      if (exact) check("pinPulse", oe, `MRG_DRIVE_CYC);
      if (exact) check("coreHeld", m, `MRG_DRIVE_CYC + `MRG_HOLD_CYC);
      check("vectorLoad", 32'(vectorLoad), 1);
      check("vectorAddr", 32'(vectorAddr), 32'h0000_FFFE);
      repeat (20) @(negedge clk);
   endtask : runSeq
   // Main sequence: hand-written corners with random fetch addresses between them.
   initial begin
      logic [15:0] a;
      logic [31:0] pre [3];
      logic [31:0] bad [3];
      int m;
      int len;
      pre = '{32'h0000_00C0, 32'h0000_00C0, 32'h0000_00E0};
      bad = '{32'h0000_0000, 32'h0000_0040, 32'h0000_00A0};
      {rst, psel, penable, pwrite, fetchValid, watchdogReq, holdReq} = 7'h40;
      paddr = '0;
      pwdata = '0;
      fetchAddr = '0;
      void'($urandom(68778));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      runSeq(1'b0, m);
      apb(1'b0, 12'h000, 0, 1'b0);
      check("clkCtlReset", rdData, 32'h0000_0080);
      apb(1'b0, 12'h004, 0, 1'b0);
      check("trapCtlReset", rdData, 32'h0000_0002);
      apb(1'b0, 12'h00C, 0, 1'b1);
      check("unmapped", rdData, 0);
      fetch(16'h0010, 1'b0);
      runSeq(1'b1, m);
      fetch(16'h0FF0, 1'b0);
      runSeq(1'b1, m);
      fetch(16'h0100, 1'b0);
      repeat (5) @(negedge clk);
      check("ramUncovered", 32'(cpuReset), 0);
      apb(1'b1, 12'h004, 32'h0000_0001, 1'b0);
      fetch(16'h0100, 1'b1);
      fetch(16'h003F, 1'b1);
      fetch(16'h0F80, 1'b1);
      // Fetches above the trap regions must never trap.
      repeat (20) begin
         a = 16'h1000 + 16'($urandom_range(0, 32'h0000_EFFF));
         fetch(a, 1'b0);
      end
      check("irqNoReset", 32'(cpuReset), 0);
      apb(1'b1, 12'h004, 32'h0000_0003, 1'b0);
      fetch(16'h023F, 1'b0);
      runSeq(1'b1, m);
      apb(1'b0, 12'h004, 0, 1'b0);
      check("trapCtlReinit", rdData, 32'h0000_0002);
      apb(1'b1, 12'h008, 32'h0000_000F, 1'b0);
      @(posedge clk);
      watchdogReq <= 1'b1;
      @(posedge clk);
      watchdogReq <= 1'b0;
      @(negedge clk);
      runSeq(1'b1, m);
      apb(1'b0, 12'h008, 0, 1'b0);
      check("wdCause", rdData, 32'h0000_0104);
      // Each illegal oscillator write, set up from a legal state.
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 12'h000, pre[i], 1'b0);
         apb(1'b1, 12'h000, bad[i], 1'b0);
         @(negedge clk);
         check("oscKept", 32'({sysCtl.hfOscEn, sysCtl.lfOscEn}), 3);
         runSeq(1'b1, m);
      end
      apb(1'b1, 12'h000, 32'h0000_00C0, 1'b0);
      apb(1'b0, 12'h000, 0, 1'b0);
      check("legalOsc", rdData | 32'(cpuReset), 32'h0000_00C0);
      len = 12 + $urandom_range(0, 20);
      @(posedge clk);
      holdReq <= 1'b1;
      repeat (len) @(posedge clk);
      holdReq <= 1'b0;
      @(negedge clk);
      check("pinReset", 32'({cpuReset, resetNOe}), 2);
      runSeq(1'b0, m);
      check("pinRelease", 32'(m <= 6), 1);
      // A second power-up in mid-run must again give exactly one full pin pulse and no causes.
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      runSeq(1'b1, m);
      apb(1'b0, 12'h008, 0, 1'b0);
      check("causeAfterPowerUp", rdData, 32'h0000_0100);
      finalReport();
   end
   // Hang guard: the whole run needs well under a thousand cycles.
   initial begin
      repeat (20000) @(posedge clk);
      nFail++;
      finalReport();
   end
endmodule : tb
